// file: verilog/lss_regs.svh
// Constants for the serial-controlled sixteen-channel low-side switch
`ifndef LSS_REGS_SVH
`define LSS_REGS_SVH

`define FRAME_BITS 16
`define CNT_W 5
`define MODE_HI 15
`define MODE_LO 8
`define GROUP_NIBBLE_HI 3
`define OP_NIBBLE_LO 4
`define NIB_ALL_LOW 4'h0
`define NIB_ALL_HIGH 4'hF
`define OP_DIAG 4'h0
`define OP_READBACK 4'hC
`define OP_ECHO 4'hA
`define OP_OR 4'h3
`define OP_AND 4'hF
`define DIAG_NO_FAULT 2'h3
`define OUTPUTS_OFF 16'h0000
`define SHIFT_CLEAR 16'h0000
`define SYNC_STAGES 2
// Idle pin levels: select, reset pin and polarity high, clock low
`define SYNC_IDLE 13'h0B00

`endif

// file: verilog/lss_pkg.sv
// Types shared by the switch control logic
package lss_pkg;

   typedef enum logic [2:0]
   {
      CMD_DIAG = 3'h0,
      CMD_READBACK = 3'h1,
      CMD_ECHO = 3'h2,
      CMD_OR = 3'h3,
      CMD_AND = 3'h4,
      CMD_BAD = 3'h5
   } cmd_type;

   typedef enum logic [1:0]
   {
      SO_FULL_DIAG = 2'h0,
      SO_READBACK = 2'h1,
      SO_ECHO = 2'h2,
      SO_ZERO = 2'h3
   } so_mode_type;

   typedef enum logic
   {
      ST_IDLE = 1'b0,
      ST_FRAME = 1'b1
   } link_state_type;

endpackage

// file: verilog/link_rx_if.sv
// Carrier between the serial-clock receiver and the system-clock core
`timescale 1ns/100ps
interface link_rx_if;
   logic sclk;
   logic si;
   logic cs_n;
   logic reset_pin_n;
   logic [15:0] rx_word;

   modport rx
   (
      input sclk,
      input si,
      input cs_n,
      input reset_pin_n,
      output rx_word
   );

   modport core
   (
      output sclk,
      output si,
      output cs_n,
      output reset_pin_n,
      input rx_word
   );
endinterface

// file: verilog/link_rx.sv
// Receive shift register clocked by the serial link clock
`timescale 1ns/100ps
`include "lss_regs.svh"
module link_rx
(
   link_rx_if.rx lnk
);
   logic [15:0] shift_q;

   // Word is stable from the last falling edge until the next frame;
   // the core reads it only after chip select has been seen high.
   always_ff @(negedge lnk.sclk or negedge lnk.reset_pin_n)
   begin
      if (!lnk.reset_pin_n)
      begin
         shift_q <= `SHIFT_CLEAR;
      end
      else if (!lnk.cs_n)
      begin
         shift_q <= {shift_q[14:0], lnk.si};
      end
   end

   assign lnk.rx_word = shift_q;
endmodule

// file: verilog/spi_low_side_switch_control.sv
// Serial control core of the sixteen-channel low-side switch
`timescale 1ns/100ps
`include "lss_regs.svh"
module spi_low_side_switch_control
   import lss_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic reset_pin_n_i,
   input wire logic input_polarity_select_i,
   input wire logic [3:0] parallel_inputs_low_group_i,
   input wire logic [3:0] parallel_inputs_high_group_i,
   input wire logic [31:0] channel_diag_i,
   output logic so_o,
   output logic so_oe_o,
   output logic [15:0] channel_on_o,
   output logic frame_error_o
);

   // ******************************************************
   // Receiver in the link clock domain
   // ******************************************************

   link_rx_if lnk ();

   assign lnk.sclk = sclk_i;
   assign lnk.si = si_i;
   assign lnk.cs_n = cs_n_i;
   assign lnk.reset_pin_n = reset_pin_n_i;

   link_rx u_link_rx
   (
      .lnk(lnk)
   );

   // ******************************************************
   // Pin synchronisers
   // ******************************************************

   // Bit order: sclk, cs_n, si, reset pin, polarity, 8 parallel inputs
   logic [12:0] sync1_q;
   logic [12:0] sync2_q;
   logic sclk_prev_q;
   logic cs_prev_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         // Idle levels, or a false select edge and pin reset follow release
         sync1_q <= `SYNC_IDLE;
         sync2_q <= `SYNC_IDLE;
      end
      else
      begin
         sync1_q <= {sclk_i, cs_n_i, si_i, reset_pin_n_i, input_polarity_select_i,
                     parallel_inputs_high_group_i, parallel_inputs_low_group_i};
         sync2_q <= sync1_q;
      end
   end

   logic sclk_s;
   logic cs_n_s;
   logic si_s;
   logic reset_pin_n_s;
   logic polarity_s;
   logic [7:0] par_in_s;

   assign sclk_s = sync2_q[12];
   assign cs_n_s = sync2_q[11];
   assign si_s = sync2_q[10];
   assign reset_pin_n_s = sync2_q[9];
   assign polarity_s = sync2_q[8];
   assign par_in_s = sync2_q[7:0];

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end
      else
      begin
         sclk_prev_q <= sclk_s;
         cs_prev_q <= cs_n_s;
      end
   end

   logic dev_reset;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;

   // Pin reset is level-acting; outputs stay off for as long as it is low
   assign dev_reset = reset_i | ~reset_pin_n_s;
   assign cs_fall = cs_prev_q & ~cs_n_s;
   assign cs_rise = ~cs_prev_q & cs_n_s;
   assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_prev_q;
   assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_prev_q;

   // ******************************************************
   // Decoding
   // ******************************************************

   function automatic cmd_type decode_mode(input logic [7:0] mode_byte);
      logic [3:0] grp;
      logic [3:0] op;
      cmd_type cmd;
      grp = mode_byte[`GROUP_NIBBLE_HI:0];
      op = mode_byte[7:`OP_NIBBLE_LO];
      cmd = CMD_BAD;
      if ((grp == `NIB_ALL_LOW) || (grp == `NIB_ALL_HIGH))
      begin
         unique case (op)
            `OP_DIAG: cmd = CMD_DIAG;
            `OP_READBACK: cmd = CMD_READBACK;
            `OP_ECHO: cmd = CMD_ECHO;
            `OP_OR: cmd = CMD_OR;
            `OP_AND: cmd = CMD_AND;
            default: cmd = CMD_BAD;
         endcase
      end
      return cmd;
   endfunction

   // Diagnosis pair 2'b11 means no fault on that channel
   function automatic logic [7:0] fault_flags(input logic [15:0] pairs);
      logic [7:0] f;
      f = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         f[i] = (pairs[2*i +: 2] == `DIAG_NO_FAULT);
      end
      return f;
   endfunction

   // ******************************************************
   // Frame tracking
   // ******************************************************

   link_state_type state_q;
   logic [`CNT_W-1:0] edge_cnt_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (dev_reset)
      begin
         state_q <= ST_IDLE;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               if (cs_fall)
               begin
                  state_q <= ST_FRAME;
               end
            end
            ST_FRAME:
            begin
               if (cs_rise)
               begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (dev_reset || cs_fall)
      begin
         edge_cnt_q <= '0;
      end
      else if (sclk_fall && (edge_cnt_q != '1))
      begin
         edge_cnt_q <= edge_cnt_q + `CNT_W'(1);
      end
   end

   logic frame_ok;
   logic [15:0] rx_word;
   cmd_type rx_cmd;
   logic rx_group_high;

   assign rx_word = lnk.rx_word;
   assign frame_ok = (state_q == ST_FRAME) && cs_rise &&
                     (edge_cnt_q == `CNT_W'(`FRAME_BITS));
   assign rx_cmd = decode_mode(rx_word[`MODE_HI:`MODE_LO]);
   assign rx_group_high = rx_word[`MODE_LO];

   always_ff @(posedge clk_sys_i)
   begin
      if (dev_reset)
      begin
         frame_error_o <= 1'b0;
      end
      else if ((state_q == ST_FRAME) && cs_rise)
      begin
         frame_error_o <= ~frame_ok;
      end
   end

   // ******************************************************
   // Output latches and boolean operation
   // ******************************************************

   logic [15:0] data_q;
   logic and_low_q;
   logic and_high_q;
   logic apply;

   // Diagnosis, readback and echo leave the output latches alone
   assign apply = frame_ok && ((rx_cmd == CMD_OR) || (rx_cmd == CMD_AND));

   always_ff @(posedge clk_sys_i)
   begin
      if (dev_reset)
      begin
         data_q <= `OUTPUTS_OFF;
      end
      else if (apply && rx_group_high)
      begin
         data_q[15:8] <= rx_word[7:0];
      end
      else if (apply)
      begin
         data_q[7:0] <= rx_word[7:0];
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (dev_reset)
      begin
         and_low_q <= 1'b0;
         and_high_q <= 1'b0;
      end
      else if (apply && rx_group_high)
      begin
         and_high_q <= (rx_cmd == CMD_AND);
      end
      else if (apply)
      begin
         and_low_q <= (rx_cmd == CMD_AND);
      end
   end

   // Input pull structures are analog; a floating pin arrives here inactive,
   // and a floating polarity pin arrives high.
   logic [7:0] par_active;

   assign par_active = polarity_s ? par_in_s : ~par_in_s;

   logic [15:0] chan_d;

   always_comb
   begin
      chan_d = data_q;
      for (int i = 0; i < 4; i++)
      begin
         chan_d[i] = and_low_q ? (par_active[i] & data_q[i])
                               : (par_active[i] | data_q[i]);
         chan_d[8+i] = and_high_q ? (par_active[4+i] & data_q[8+i])
                                  : (par_active[4+i] | data_q[8+i]);
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (dev_reset)
      begin
         channel_on_o <= `OUTPUTS_OFF;
      end
      else
      begin
         channel_on_o <= chan_d;
      end
   end

   // ******************************************************
   // Content of the next response
   // ******************************************************

   so_mode_type so_mode_q;
   logic resp_high_q;

   // One-shot modes fall back to full diagnosis after a single frame
   always_ff @(posedge clk_sys_i)
   begin
      if (dev_reset)
      begin
         so_mode_q <= SO_FULL_DIAG;
         resp_high_q <= 1'b0;
      end
      else if (frame_ok)
      begin
         resp_high_q <= rx_group_high;
         unique case (rx_cmd)
            CMD_READBACK: so_mode_q <= SO_READBACK;
            CMD_ECHO: so_mode_q <= SO_ECHO;
            CMD_BAD: so_mode_q <= SO_ZERO;
            default: so_mode_q <= SO_FULL_DIAG;
         endcase
      end
      else if ((state_q == ST_FRAME) && cs_rise)
      begin
         so_mode_q <= SO_FULL_DIAG;
      end
   end

   logic [15:0] diag_pairs;
   logic [15:0] load_word;

   // Fault latching is done by the analog monitor feeding channel_diag_i
   assign diag_pairs = resp_high_q ? channel_diag_i[31:16] : channel_diag_i[15:0];

   always_comb
   begin
      unique case (so_mode_q)
         SO_FULL_DIAG: load_word = diag_pairs;
         SO_READBACK: load_word = {par_in_s, fault_flags(diag_pairs)};
         SO_ECHO: load_word = `SHIFT_CLEAR;
         SO_ZERO: load_word = `SHIFT_CLEAR;
      endcase
   end

   // ******************************************************
   // Transmit shift register and serial output
   // ******************************************************

   logic [15:0] tx_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (dev_reset)
      begin
         tx_q <= `SHIFT_CLEAR;
      end
      else if (cs_fall)
      begin
         tx_q <= load_word;
      end
      else if (sclk_rise)
      begin
         tx_q <= {tx_q[14:0], 1'b0};
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (dev_reset || cs_n_s)
      begin
         so_oe_o <= 1'b0;
      end
      else
      begin
         so_oe_o <= 1'b1;
      end
   end

   // Echo follows the synchronised input, so the loop adds sync latency
   always_ff @(posedge clk_sys_i)
   begin
      if (dev_reset || cs_n_s)
      begin
         so_o <= 1'b0;
      end
      else if (so_mode_q == SO_ECHO)
      begin
         so_o <= si_s;
      end
      else if (cs_fall)
      begin
         so_o <= load_word[15];
      end
      else if (sclk_rise)
      begin
         so_o <= tx_q[14];
      end
   end

endmodule

// file: dv/lss_checker.sv
// Port checker for the switch control core
`timescale 1ns/100ps
module lss_checker
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic reset_pin_n_i,
   input wire logic input_polarity_select_i,
   input wire logic [3:0] parallel_inputs_low_group_i,
   input wire logic [3:0] parallel_inputs_high_group_i,
   input wire logic so_o,
   input wire logic so_oe_o,
   input wire logic [15:0] channel_on_o,
   input wire logic frame_error_o
);
   logic [8:0] par_q;
   logic [3:0] quiet_q;
   wire [8:0] par_now = {input_polarity_select_i, parallel_inputs_low_group_i,
      parallel_inputs_high_group_i};

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   // ****************
   // Helper logic
   // ****************
   always_ff @(posedge clk_sys_i)
   begin
      par_q <= par_now;
   end

   // Pins reach the outputs late, so a recent move excuses a change
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || par_q != par_now)
         quiet_q <= 4'h0;
      else if (quiet_q != 4'hF)
         quiet_q <= quiet_q + 4'h1;
   end

   // ****************
   // Assertions
   // ****************
   a_idle_hiz: assert property (cs_n_i [*5] |-> !so_oe_o)
      else $error("serial output driven while deselected");
   a_released_low: assert property (!so_oe_o |-> !so_o)
      else $error("serial output not parked low");
   a_oe_rise: assert property ($fell(cs_n_i) |-> ##[2:4] so_oe_o)
      else $error("serial output not enabled after select");
   a_oe_fall: assert property ($rose(cs_n_i) |-> ##[2:4] !so_oe_o)
      else $error("serial output not released after deselect");
   // Echo frames loop the input back, so a move may also follow the input
   a_so_shift: assert property (so_oe_o && $past(so_oe_o) && !cs_n_i && $changed(so_o)
      |-> $past(sclk_i, 3) || so_o == $past(si_i, 3))
      else $error("serial output moved without a clock rise");
   a_pin_clear: assert property (!reset_pin_n_i [*5] |-> channel_on_o == 16'h0000)
      else $error("channels on during pin reset");
   a_err_closed: assert property ($changed(frame_error_o) |-> cs_n_i)
      else $error("frame error moved inside a frame");
   a_out_hold: assert property ($changed(channel_on_o) |-> cs_n_i || quiet_q < 4'h8)
      else $error("channels moved inside a frame");

   c_frame: cover property ($fell(cs_n_i));
   c_err: cover property ($rose(frame_error_o));
   c_apply: cover property ($changed(channel_on_o) && cs_n_i);
endmodule

bind spi_low_side_switch_control lss_checker u_lss_checker
(
   .clk_sys_i,
   .reset_i,
   .sclk_i,
   .cs_n_i,
   .si_i,
   .reset_pin_n_i,
   .input_polarity_select_i,
   .parallel_inputs_low_group_i,
   .parallel_inputs_high_group_i,
   .so_o,
   .so_oe_o,
   .channel_on_o,
   .frame_error_o
);

// file: dv/spi_host_model.sv
// Host model acting as master of the serial link
`timescale 1ns/100ps
module spi_host_model
(
   input wire logic so_i,
   input wire logic so_oe_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic si_o
);
   int gap_ns = 250;

   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end

   // ****************
   // Transfers
   // ****************
   // Released output reads as z, so a missing enable never matches
   task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      cs_n_o = 1'b0;
      #200;
      for (int i = 0; i < n; i++)
      begin
         si_o = tx[15 - i];
         #40;
         // Bit stands from the previous rise, so take it before this one
         rx = {rx[14:0], so_oe_i ? so_i : 1'bz};
         sclk_o = 1'b1;
         #80;
         sclk_o = 1'b0;
         #40;
      end
      si_o = 1'b0;
      #160;
      cs_n_o = 1'b1;
      #(gap_ns);
   endtask

   task automatic stray();
      for (int i = 0; i < 16; i++)
      begin
         si_o = i[0];
         sclk_o = 1'b1;
         #80;
         sclk_o = 1'b0;
         #80;
      end
      si_o = 1'b0;
   endtask
endmodule

// file: dv/spi_low_side_switch_control_test.sv
// Self-checking bench for the switch control core
`timescale 1ns/100ps
module spi_low_side_switch_control_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pin_n = 1'b1;
   logic pol = 1'b1;
   logic [3:0] par_lo = 4'h0;
   logic [3:0] par_hi = 4'h0;
   logic [31:0] diag = 32'h6C39D2B4;
   logic [15:0] rx;
   logic [15:0] on;
   logic so, so_oe, ferr;
   wire sclk, cs_n, si;
   int err_total = 0;
   int compares = 0;

   spi_low_side_switch_control u_spi_low_side_switch_control
   (
      .clk_sys_i(clk),
      .reset_i(rst),
      .sclk_i(sclk),
      .cs_n_i(cs_n),
      .si_i(si),
      .reset_pin_n_i(pin_n),
      .input_polarity_select_i(pol),
      .parallel_inputs_low_group_i(par_lo),
      .parallel_inputs_high_group_i(par_hi),
      .channel_diag_i(diag),
      .so_o(so),
      .so_oe_o(so_oe),
      .channel_on_o(on),
      .frame_error_o(ferr)
   );

   spi_host_model u_spi_host_model
   (
      .so_i(so),
      .so_oe_i(so_oe),
      .sclk_o(sclk),
      .cs_n_o(cs_n),
      .si_o(si)
   );

   initial
   begin
      forever #5 clk = ~clk;
   end

   // ****************
   // Helpers
   // ****************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Pins move off the sampling edge, then settle past the pin latency
   task automatic pins(input logic p, input logic [3:0] lo, input logic [3:0] hi);
      @(negedge clk);
      pol = p;
      par_lo = lo;
      par_hi = hi;
      repeat (8) @(negedge clk);
   endtask

   task automatic fr(input logic [15:0] tx, input int n);
      u_spi_host_model.frame(tx, n, rx);
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_or_default();
      pins(1'b1, 4'h3, 4'h5);
      fr(16'h3050, 16);
      chk(rx, diag[15:0]);
      chk(on, 16'h0553);
      fr(16'h3F0C, 16);
      chk(on, 16'h0D53);
   endtask

   task automatic t_and_latch();
      @(negedge clk);
      diag = 32'hA5C31E78;
      fr(16'hF05A, 16);
      chk(rx, diag[31:16]);
      chk(on, 16'h0D52);
      fr(16'h00FF, 16);
      chk(rx, diag[15:0]);
      chk(on, 16'h0D52);
      pins(1'b1, 4'hF, 4'h5);
      chk(on, 16'h0D5A);
      pins(1'b0, 4'hC, 4'h5);
      chk(on, 16'h0E52);
   endtask

   task automatic t_bad_word();
      fr(16'h70FF, 16);
      chk(on, 16'h0E52);
      fr(16'h0000, 16);
      chk(rx, 16'h0000);
   endtask

   task automatic t_short();
      u_spi_host_model.gap_ns = 200000;
      fr(16'h30FF, 15);
      chk(on, 16'h0E52);
      chk({15'h0000, ferr}, 16'h0001);
      u_spi_host_model.gap_ns = 250;
      fr(16'h3000, 16);
      chk(rx, diag[15:0]);
      chk({15'h0000, ferr}, 16'h0000);
      chk(on, 16'h0E03);
   endtask

   task automatic t_stray();
      u_spi_host_model.stray();
      repeat (8) @(negedge clk);
      chk(on, 16'h0E03);
      chk({15'h0000, so_oe}, 16'h0000);
   endtask

   task automatic t_modes();
      fr(16'hC000, 16);
      chk(rx, diag[15:0]);
      fr(16'hA000, 16);
      chk(rx, 16'h5C24);
      fr(16'h0FA5, 16);
      chk(rx, 16'h0FA5);
      fr(16'h0000, 16);
      chk(rx, diag[31:16]);
      chk(on, 16'h0E03);
   endtask

   task automatic t_pin();
      @(negedge clk);
      pin_n = 1'b0;
      repeat (10) @(negedge clk);
      chk(on, 16'h0000);
      pin_n = 1'b1;
      repeat (10) @(negedge clk);
      chk(on, 16'h0A03);
   endtask

   initial
   begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (5) @(negedge clk);
      t_or_default();
      t_and_latch();
      t_bad_word();
      t_short();
      t_stray();
      t_modes();
      t_pin();
      wrap_up();
   end

   // Whole run takes under half of this span
   initial
   begin
      #600000;
      err_total++;
      wrap_up();
   end
endmodule
